// file: design/fbm_pkg.sv
// Purpose: Constants and types for the flyback mode and protection sequencer
// Assumes: 50 MHz pclk, comparator inputs synchronous to pclk
// Notes: Long counts are overridable parameters of the top module
package fbm_pkg;
    localparam int CLK_MHZ = 50;
    localparam int TW = 27;
    localparam int CW = 4;
    // APB register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_FAULT = 8'h08;
    localparam logic [7:0] OFS_FREQ = 8'h0c;
    // Control bits
    localparam int CTRL_CCM = 0;
    localparam int CTRL_OVP_LATCH = 1;
    localparam int CTRL_SD_LATCH = 2;
    localparam int CTRL_UVP_LONG = 3;
    localparam logic [3:0] CTRL_RST = 4'h0;
    // Fault cause bits
    localparam int F_VOVP = 0;
    localparam int F_BRO = 1;
    localparam int F_BIF = 2;
    localparam int F_OTP = 3;
    localparam int F_AOVP = 4;
    localparam int F_AUVP = 5;
    localparam int F_SD = 6;
    localparam int F_CS = 7;
    localparam int NF = 8;
    // Timer and cycle counter indices
    localparam int T_DEEP = 0;
    localparam int T_VOVP = 1;
    localparam int T_BRO = 2;
    localparam int T_SD = 3;
    localparam int T_LAR = 4;
    localparam int T_UBNK = 5;
    localparam int T_BICHK = 6;
    localparam int NT = 7;
    localparam int C_BI = 0;
    localparam int C_AOVP = 1;
    localparam int C_AUVP = 2;
    localparam int C_CS = 3;
    localparam int NC = 4;
    // Times and derived cycle counts
    localparam int AUX_BLANK_NS = 120;
    localparam int AUX_BLANK_CYC = (AUX_BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int CS_DEB_NS = 300;
    localparam int CS_DEB_CYC = (CS_DEB_NS * CLK_MHZ + 999) / 1000;
    localparam int TON_LIM_NS = 1000;
    localparam int TON_LIM_CYC = TON_LIM_NS * CLK_MHZ / 1000;
    localparam int DEEP_US = 100000;
    localparam int VOVP_US = 100;
    localparam int BRO_US = 50000;
    localparam int SD_US = 100;
    localparam int LAR_US = 1000000;
    localparam int UBNK_US = 50000;
    localparam int BICHK_US = 10000;
    // Switching cycle debounce counts
    localparam logic [CW-1:0] LINE_ON_DEBOUNCE_CYCLES = 4'h4;
    localparam logic [CW-1:0] N_AOVP = 4'h3;
    localparam logic [CW-1:0] N_AUVP = 4'h8;
    localparam logic [CW-1:0] N_CS = 4'h4;
    // Frequency limits in kHz and load breakpoints
    localparam logic [7:0] F_TMO = 8'h19;
    localparam logic [7:0] F_MAX_LL = 8'h96;
    localparam logic [7:0] F_MAX_HL = 8'hc8;
    localparam logic [7:0] F_MAX_CCM = 8'h64;
    localparam logic [7:0] LOAD_LIGHT = 8'h40;
    localparam logic [7:0] LOAD_HEAVY = 8'h80;
    localparam int LOAD_SHIFT = 6;
    typedef enum logic [4:0] {
        ST_CHARGE = 5'b00001,
        ST_RUN = 5'b00010,
        ST_AR = 5'b00100,
        ST_LAR = 5'b01000,
        ST_LATCH = 5'b10000
    } fbm_state_t;
endpackage

// file: design/fbm_seq.sv
// Purpose: Mode and protection sequencer of a quasi-resonant flyback controller
// Assumes: Comparator flags are synchronous to pclk; pwm_req comes from the PWM loop
// Notes: APB3 slave, zero wait states
// Functional notes
// - Stop pulses when feedback drops below burst enter level, each time.
// - Resume above burst exit level; cap peak current at minimum in burst.
// - Feedback below enter level past deep mode delay enters deep mode.
// - Deep mode leaves at once when feedback rises above exit level.
// - Frequency limit: timeout at light, modulated at medium, maximum at heavy load.
// - Frequency limit never above the maximum for present line.
// - Optional continuous conduction at low line, capped at its own limit.
// - Aux sense sampled at end of aux blanking after turn-off.
// - Aux pin clamped during conduction; its current gives line level.
// - Charge path on until turn-on level, then off, switch, check line.
// - No line-on detection after start of switching enters auto-restart.
// - Line-on needs current above level for debounce cycles in conduction.
// - Line current below off level past debounce time is a fault.
// - Supply above over-voltage for debounce time gives auto-restart.
// - Over-temperature stops pulses and enters protection.
// - Aux over-voltage past cycle count stops pulses; restart or latch.
// - Aux under-voltage past cycle count; restart or long restart.
// - Aux under-voltage ignored during start-up blanking.
// - Start-up shutdown threshold first, normal threshold after start-up.
// - Shutdown pin low for debounce time; restart or latch.
// - Current sense short limits on-time; consecutive cycles give restart.
// - Long restart keeps switch off for interval, resumes if supply on.
// - All faults restart; aux OVP and shutdown latchable; UVP long-restartable.
`timescale 1ns/1ps
module fbm_seq
    import fbm_pkg::*;
#(
    parameter int unsigned P_DEEP_CYC = DEEP_US * CLK_MHZ,
    parameter int unsigned P_VOVP_CYC = VOVP_US * CLK_MHZ,
    parameter int unsigned P_BRO_CYC = BRO_US * CLK_MHZ,
    parameter int unsigned P_SD_CYC = SD_US * CLK_MHZ,
    parameter int unsigned P_LAR_CYC = LAR_US * CLK_MHZ,
    parameter int unsigned P_UBNK_CYC = UBNK_US * CLK_MHZ,
    parameter int unsigned P_BICHK_CYC = BICHK_US * CLK_MHZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pwm_req,
    input wire logic [7:0] load_level,
    input wire logic low_line,
    input wire logic fb_below_enter,
    input wire logic fb_above_exit,
    input wire logic vdd_above_on,
    input wire logic vdd_below_uvlo,
    input wire logic vdd_above_ovp,
    input wire logic line_cur_above_on,
    input wire logic line_cur_below_off,
    input wire logic aux_above_ovp,
    input wire logic aux_below_uvp,
    input wire logic otp_hot,
    input wire logic sd_below_start,
    input wire logic sd_below_norm,
    input wire logic cs_below_short,
    output logic gate_on,
    output logic hv_charge_en,
    output logic deep_mode,
    output logic cs_min_cap,
    output logic aux_clamp_en,
    output logic aux_sample,
    output logic ton_limit,
    output logic sd_startup_sel,
    output logic ccm_allowed,
    output logic [7:0] freq_limit
);
    localparam logic [TW-1:0] T_LIM [NT] = '{TW'(P_DEEP_CYC), TW'(P_VOVP_CYC),
        TW'(P_BRO_CYC), TW'(P_SD_CYC), TW'(P_LAR_CYC), TW'(P_UBNK_CYC),
        TW'(P_BICHK_CYC)};
    localparam logic [CW-1:0] C_LIM [NC] = '{LINE_ON_DEBOUNCE_CYCLES, N_AOVP + 4'h1,
        N_AUVP + 4'h1, N_CS};
    localparam logic [7:0] BLANK_LD = 8'(AUX_BLANK_CYC);
    localparam logic [7:0] CS_DEB = 8'(CS_DEB_CYC);
    localparam logic [7:0] TON_LIM = 8'(TON_LIM_CYC);

    fbm_state_t st_reg, st_next;
    logic [3:0] ctrl_reg;
    logic [NF-1:0] fault_reg, f_now, f_other;
    logic [31:0] prdata_reg;
    logic gate_reg, gate_prev_reg, gate_next;
    logic burst_reg, burst_next, deep_reg, cs_min_reg, brown_in_reg;
    logic hv_reg, sd_start_reg, line_hi_reg, line_lo_reg, cs_short_reg;
    logic aux_sample_reg;
    logic [7:0] blank_cnt, ton_cnt, freq_reg, fmax, fmed;
    logic [15:0] fprod;
    logic st_run, on_evt, off_evt, ton_kill, fault_go;
    logic to_latch, to_lar, to_ar, ccm_act, sd_low;
    logic [TW-1:0] t_cnt [NT];
    logic [NT-1:0] t_lvl, t_hit, t_sat;
    logic [CW-1:0] c_cnt [NC];
    logic [NC-1:0] c_evt, c_cond, c_hit;

    assign st_run = (st_reg == ST_RUN);
    assign on_evt = gate_reg & ~gate_prev_reg;
    assign off_evt = gate_prev_reg & ~gate_reg;

    // APB slave
    logic acc, wr_acc, mapped;
    assign acc = psel & penable;
    assign wr_acc = acc & pwrite;
    assign mapped = (paddr == OFS_CTRL) | (paddr == OFS_STATUS) |
                    (paddr == OFS_FAULT) | (paddr == OFS_FREQ);
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata = prdata_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RST;
        end else if (wr_acc && paddr == OFS_CTRL) begin
            ctrl_reg <= pwdata[3:0];
        end
    end

    // Sticky causes, write one to clear; a new fault wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_reg <= '0;
        end else if (wr_acc && paddr == OFS_FAULT) begin
            fault_reg <= (fault_reg & ~pwdata[NF-1:0]) | f_now;
        end else begin
            fault_reg <= fault_reg | f_now;
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                OFS_CTRL: prdata_reg <= {28'h0000000, ctrl_reg};
                OFS_STATUS: prdata_reg <= {23'h000000, brown_in_reg, burst_reg,
                    deep_reg, cs_min_reg, st_reg};
                OFS_FAULT: prdata_reg <= {24'h000000, fault_reg};
                OFS_FREQ: prdata_reg <= {24'h000000, freq_reg};
                default: prdata_reg <= '0;
            endcase
        end
    end

    // Time debounce timers, saturating at their limit
    generate
        for (genvar i = 0; i < NT; i++) begin : g_tmr
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    t_cnt[i] <= '0;
                end else if (!t_lvl[i]) begin
                    t_cnt[i] <= '0;
                end else if (t_cnt[i] != T_LIM[i]) begin
                    t_cnt[i] <= t_cnt[i] + 1'b1;
                end
            end
            assign t_hit[i] = t_lvl[i] && (t_cnt[i] == T_LIM[i] - 1'b1);
            assign t_sat[i] = (t_cnt[i] == T_LIM[i]);
        end
    endgenerate

    // Consecutive switching cycle counters
    generate
        for (genvar i = 0; i < NC; i++) begin : g_cyc
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    c_cnt[i] <= '0;
                end else if (!st_run) begin
                    c_cnt[i] <= '0;
                end else if (c_evt[i] && !c_cond[i]) begin
                    c_cnt[i] <= '0;
                end else if (c_evt[i] && c_cnt[i] != C_LIM[i]) begin
                    c_cnt[i] <= c_cnt[i] + 1'b1;
                end
            end
            assign c_hit[i] = st_run && c_evt[i] && c_cond[i] &&
                              (c_cnt[i] == C_LIM[i] - 1'b1);
        end
    endgenerate

    assign sd_low = sd_start_reg ? sd_below_start : sd_below_norm;
    assign t_lvl[T_DEEP] = st_run & fb_below_enter;
    assign t_lvl[T_VOVP] = st_run & vdd_above_ovp;
    assign t_lvl[T_BRO] = st_run & brown_in_reg & line_lo_reg;
    assign t_lvl[T_SD] = st_run & sd_low;
    assign t_lvl[T_LAR] = (st_reg == ST_LAR);
    assign t_lvl[T_UBNK] = st_run;
    assign t_lvl[T_BICHK] = st_run & ~brown_in_reg;

    assign c_evt[C_BI] = off_evt;
    assign c_cond[C_BI] = line_hi_reg;
    assign c_evt[C_AOVP] = aux_sample_reg;
    assign c_cond[C_AOVP] = aux_above_ovp;
    assign c_evt[C_AUVP] = aux_sample_reg & t_sat[T_UBNK];
    assign c_cond[C_AUVP] = aux_below_uvp;
    assign c_evt[C_CS] = off_evt;
    assign c_cond[C_CS] = cs_short_reg;

    // Fault sources, live only while running
    always_comb begin
        f_now = '0;
        f_now[F_VOVP] = t_hit[T_VOVP];
        f_now[F_BRO] = t_hit[T_BRO];
        f_now[F_BIF] = t_hit[T_BICHK];
        f_now[F_OTP] = st_run & otp_hot;
        f_now[F_AOVP] = c_hit[C_AOVP];
        f_now[F_AUVP] = c_hit[C_AUVP];
        f_now[F_SD] = t_hit[T_SD];
        f_now[F_CS] = c_hit[C_CS];
        f_other = f_now;
        f_other[F_AUVP] = 1'b0;
    end

    // Response selection
    assign fault_go = |f_now;
    assign to_latch = (f_now[F_AOVP] & ctrl_reg[CTRL_OVP_LATCH]) |
                      (f_now[F_SD] & ctrl_reg[CTRL_SD_LATCH]);
    assign to_lar = f_now[F_AUVP] & ctrl_reg[CTRL_UVP_LONG] & ~(|f_other);
    assign to_ar = fault_go & ~to_latch & ~to_lar;

    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            ST_CHARGE: begin
                if (vdd_above_on) st_next = ST_RUN;
            end
            ST_RUN: begin
                if (vdd_below_uvlo) st_next = ST_CHARGE;
                else if (to_latch) st_next = ST_LATCH;
                else if (to_ar) st_next = ST_AR;
                else if (to_lar) st_next = ST_LAR;
            end
            ST_AR: begin
                if (vdd_below_uvlo) st_next = ST_CHARGE;
            end
            ST_LAR: begin
                if (t_hit[T_LAR]) begin
                    st_next = vdd_above_on ? ST_RUN : ST_CHARGE;
                end
            end
            ST_LATCH: begin
                if (vdd_below_uvlo) st_next = ST_CHARGE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= ST_CHARGE;
            hv_reg <= 1'b1;
        end else begin
            st_reg <= st_next;
            hv_reg <= (st_next == ST_CHARGE);
        end
    end

    // Start-up threshold until the start-up blanking has run out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sd_start_reg <= 1'b1;
        end else if (st_next == ST_CHARGE) begin
            sd_start_reg <= 1'b1;
        end else if (t_sat[T_UBNK]) begin
            sd_start_reg <= 1'b0;
        end
    end

    // Line-on flag, dropped for each new start-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brown_in_reg <= 1'b0;
        end else if (st_next == ST_CHARGE) begin
            brown_in_reg <= 1'b0;
        end else if (c_hit[C_BI]) begin
            brown_in_reg <= 1'b1;
        end
    end

    // Line current seen while clamped in conduction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_hi_reg <= 1'b0;
            line_lo_reg <= 1'b0;
        end else if (gate_reg) begin
            line_hi_reg <= on_evt ? line_cur_above_on : (line_hi_reg | line_cur_above_on);
            line_lo_reg <= line_cur_below_off;
        end
    end

    // Burst and deep mode
    always_comb begin
        burst_next = burst_reg;
        if (fb_above_exit) burst_next = 1'b0;
        else if (fb_below_enter) burst_next = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burst_reg <= 1'b0;
        end else begin
            burst_reg <= burst_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deep_reg <= 1'b0;
        end else if (fb_above_exit || !st_run) begin
            deep_reg <= 1'b0;
        end else if (t_hit[T_DEEP]) begin
            deep_reg <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_min_reg <= 1'b0;
        end else if (burst_next) begin
            cs_min_reg <= 1'b1;
        end else if (load_level >= LOAD_LIGHT) begin
            cs_min_reg <= 1'b0;
        end
    end

    // On-time counter and current sense short check
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ton_cnt <= '0;
        end else if (!gate_reg) begin
            ton_cnt <= '0;
        end else if (ton_cnt != 8'hff) begin
            ton_cnt <= ton_cnt + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_short_reg <= 1'b0;
        end else if (on_evt) begin
            cs_short_reg <= 1'b0;
        end else if (gate_reg && ton_cnt == CS_DEB - 1'b1 && cs_below_short) begin
            cs_short_reg <= 1'b1;
        end
    end

    assign ton_kill = cs_short_reg & (ton_cnt >= TON_LIM - 1'b1);

    // Gate drive
    assign gate_next = pwm_req & st_run & ~burst_next & ~ton_kill &
                       ~fault_go & ~vdd_below_uvlo;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_reg <= 1'b0;
            gate_prev_reg <= 1'b0;
        end else begin
            gate_reg <= gate_next;
            gate_prev_reg <= gate_reg;
        end
    end

    // Aux blanking after turn-off, one sample at its end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blank_cnt <= '0;
            aux_sample_reg <= 1'b0;
        end else begin
            aux_sample_reg <= !gate_reg && blank_cnt == 8'h01;
            if (gate_reg) blank_cnt <= '0;
            else if (off_evt) blank_cnt <= BLANK_LD;
            else if (blank_cnt != 8'h00) blank_cnt <= blank_cnt - 1'b1;
        end
    end

    // Frequency limit fold-back
    assign ccm_act = ctrl_reg[CTRL_CCM] & low_line;
    assign fmax = ccm_act ? F_MAX_CCM : (low_line ? F_MAX_LL : F_MAX_HL);
    assign fprod = 16'(fmax - F_TMO) * 16'(load_level - LOAD_LIGHT);
    assign fmed = F_TMO + fprod[LOAD_SHIFT+7:LOAD_SHIFT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_reg <= F_TMO;
        end else if (load_level < LOAD_LIGHT) begin
            freq_reg <= F_TMO;
        end else if (load_level >= LOAD_HEAVY) begin
            freq_reg <= fmax;
        end else begin
            freq_reg <= fmed;
        end
    end

    assign gate_on = gate_reg;
    assign hv_charge_en = hv_reg;
    assign deep_mode = deep_reg;
    assign cs_min_cap = cs_min_reg;
    assign aux_clamp_en = gate_reg;
    assign aux_sample = aux_sample_reg;
    assign ton_limit = cs_short_reg;
    assign sd_startup_sel = sd_start_reg;
    assign ccm_allowed = ccm_act;
    assign freq_limit = freq_reg;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_off_quiet;
        $fell(gate_reg) ##1 (!gate_reg) [*6];
    endsequence

    sequence s_charge_done;
        (st_reg == ST_CHARGE) && vdd_above_on;
    endsequence

    a_burst_stop: assert property (fb_below_enter && !fb_above_exit |=> !gate_reg)
        else $error("pulse issued below burst enter level");
    a_burst_resume: assert property (st_run && pwm_req && fb_above_exit && !ton_kill
        && !fault_go && !vdd_below_uvlo |=> gate_reg)
        else $error("no pulse after burst exit");
    a_deep_enter: assert property (st_run && t_hit[T_DEEP] && !fb_above_exit
        |=> deep_reg)
        else $error("deep mode not entered");
    a_deep_leave: assert property (deep_reg && fb_above_exit |=> !deep_reg)
        else $error("deep mode held after exit level");
    a_freq_cap: assert property (##1 freq_reg <= $past(fmax))
        else $error("frequency limit above maximum");
    a_aux_sample: assert property (s_off_quiet |=> aux_sample_reg)
        else $error("aux not sampled at blanking end");
    a_aux_early: assert property ($fell(gate_reg) |=> !aux_sample_reg [*6])
        else $error("aux sampled inside blanking");
    a_hv_start: assert property (s_charge_done |=> st_run && !hv_charge_en)
        else $error("charge path not released at turn-on");
    a_bi_fail: assert property (st_run && t_hit[T_BICHK] && !vdd_below_uvlo && !to_latch
        |=> st_reg == ST_AR)
        else $error("no restart without line-on");
    a_bi_cause: assert property ($rose(brown_in_reg) |-> $past(c_hit[C_BI]))
        else $error("line-on without debounce");
    a_otp_stop: assert property (st_run && otp_hot |=> !gate_reg)
        else $error("pulse during over-temperature");
    a_sd_latch: assert property (st_run && t_hit[T_SD] && ctrl_reg[CTRL_SD_LATCH]
        && !vdd_below_uvlo |=> st_reg == ST_LATCH)
        else $error("shutdown did not latch");
    a_ton_kill: assert property (gate_reg && ton_kill |=> !gate_reg)
        else $error("on-time not limited");
    a_lar_off: assert property (st_reg == ST_LAR |-> !gate_reg)
        else $error("switching during long restart");
    a_latch_hold: assert property (st_reg == ST_LATCH && !vdd_below_uvlo
        |=> st_reg == ST_LATCH && !gate_reg)
        else $error("latch released without power cycle");
endmodule

// file: verif/fbm_stage.sv
// Purpose: Power stage model seen through the aux-pin line current comparators
// Assumes: Line current is only meaningful while the switch conducts
// Notes: line_ok selects a healthy line or a missing line
`timescale 1ns/1ps
module fbm_stage (
    input wire logic gate_on,
    input wire logic line_ok,
    output logic line_cur_above_on,
    output logic line_cur_below_off
);
    // Current flows out of the clamped pin only in conduction
    assign line_cur_above_on = gate_on & line_ok;
    assign line_cur_below_off = ~line_ok;
endmodule

// file: verif/test_fbm_seq.sv
// Purpose: Self-checking bench for the flyback mode and protection sequencer
// Assumes: Shortened timer parameters, APB master at the rising edge
// Notes: Random loads and line states from a fixed seed
`timescale 1ns/1ps
module test_fbm_seq import fbm_pkg::*; ;
    logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, pwm_req = '0;
    logic [7:0] paddr = '0, load_level = '0, lv;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, pslverr, err, ll, cc, line_ok = '0, low_line = '0, otp_hot = '0;
    logic fb_below_enter = '0, fb_above_exit = '0, vdd_above_on = '0, vdd_below_uvlo = '0;
    logic vdd_above_ovp = '0, aux_above_ovp = '0, aux_below_uvp = '0, cs_below_short = '0;
    logic sd_below_start = '0, sd_below_norm = '0, line_cur_above_on, line_cur_below_off;
    logic gate_on, hv_charge_en, deep_mode, cs_min_cap, aux_clamp_en, aux_sample, ton_limit;
    logic sd_startup_sel, ccm_allowed;
    logic [7:0] freq_limit;
    logic [7:0] corner [4] = '{8'h3f, 8'h40, 8'h7f, 8'h80};
    int mismatches = 0, total_checks = 0, k;
    logic [3:0] ctl [7] = '{4'h0, 4'h0, 4'h4, 4'h0, 4'h2, 4'h8, 4'h0};
    fbm_state_t exp_st [7] = '{ST_AR, ST_AR, ST_LATCH, ST_AR, ST_LATCH, ST_CHARGE, ST_AR};
    int cause [7] = '{F_OTP, F_VOVP, F_SD, F_BIF, F_AOVP, F_AUVP, F_CS};
    always #10 pclk = ~pclk;
    fbm_seq #(.P_DEEP_CYC(20), .P_VOVP_CYC(10), .P_BRO_CYC(30), .P_SD_CYC(10),
        .P_LAR_CYC(40), .P_UBNK_CYC(50), .P_BICHK_CYC(200)) u_dut (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pwm_req,
        .load_level, .low_line, .fb_below_enter, .fb_above_exit, .vdd_above_on,
        .vdd_below_uvlo, .vdd_above_ovp, .line_cur_above_on, .line_cur_below_off,
        .aux_above_ovp, .aux_below_uvp, .otp_hot, .sd_below_start, .sd_below_norm,
        .cs_below_short, .gate_on, .hv_charge_en, .deep_mode, .cs_min_cap, .aux_clamp_en,
        .aux_sample, .ton_limit, .sd_startup_sel, .ccm_allowed, .freq_limit);
    fbm_stage u_stage (.gate_on, .line_ok, .line_cur_above_on, .line_cur_below_off);
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task print_verdict;
        if (mismatches == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task pulses(input int n);
        repeat (n) begin
            @(posedge pclk) pwm_req <= 1'b1;
            repeat (3) @(posedge pclk);
            chk("gate", gate_on, 1'b1);
            chk("clamp", aux_clamp_en, 1'b1);
            pwm_req <= 1'b0;
            k = 0;
            do begin @(posedge pclk); k++; end while (aux_sample !== 1'b1 && k < 12);
            chk("aux_sample", k, 9);
        end
    endtask
    task start;
        @(posedge pclk);
        vdd_below_uvlo <= 1'b0;
        vdd_above_on <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("hv", hv_charge_en, 1'b0);
        chk("sdsel", sd_startup_sel, 1'b1);
    endtask
    function automatic logic [7:0] fexp(logic [7:0] ld, logic lo, logic c);
        logic [7:0] fm;
        fm = (c && lo) ? F_MAX_CCM : (lo ? F_MAX_LL : F_MAX_HL);
        if (ld < LOAD_LIGHT) return F_TMO;
        if (ld >= LOAD_HEAVY) return fm;
        return F_TMO + 8'(((int'(fm) - int'(F_TMO)) * (int'(ld) - 64)) >> LOAD_SHIFT);
    endfunction
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        print_verdict;
    end
    initial begin
        void'($urandom(32'h185c5e94));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("hv", hv_charge_en, 1'b1);
        chk("freq", freq_limit, F_TMO);
        apb(1'b1, OFS_CTRL, 32'hf);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl", q, 32'hf);
        apb(1'b0, 8'h10, 32'h0);
        chk("slverr", err, 1'b1);
        chk("unmapped", q, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h0);
        line_ok <= 1'b1;
        start();
        pulses(4);
        pwm_req <= 1'b1;
        fb_below_enter <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("gate", gate_on, 1'b0);
        chk("csmin", cs_min_cap, 1'b1);
        repeat (25) @(posedge pclk);
        chk("deep", deep_mode, 1'b1);
        fb_below_enter <= 1'b0;
        fb_above_exit <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("deep", deep_mode, 1'b0);
        chk("gate", gate_on, 1'b1);
        chk("sdsel", sd_startup_sel, 1'b0);
        pwm_req <= 1'b0;
        fb_above_exit <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            lv = (i < 4) ? corner[i] : 8'($urandom);
            ll = 1'($urandom);
            cc = 1'($urandom);
            apb(1'b1, OFS_CTRL, {31'h0, cc});
            load_level <= lv;
            low_line <= ll;
            repeat (3) @(posedge pclk);
            chk("freq", freq_limit, fexp(lv, ll, cc));
            chk("ccm", ccm_allowed, cc & ll);
        end
        for (int i = 0; i < 7; i++) begin
            vdd_above_on <= 1'b0;
            vdd_below_uvlo <= 1'b1;
            {otp_hot, vdd_above_ovp, sd_below_start, sd_below_norm} <= 4'h0;
            {aux_above_ovp, aux_below_uvp, cs_below_short} <= 3'h0;
            repeat (3) @(posedge pclk);
            chk("hv", hv_charge_en, 1'b1);
            line_ok <= (i != 3);
            apb(1'b1, OFS_FAULT, 32'hff);
            apb(1'b1, OFS_CTRL, 32'(ctl[i]));
            start();
            pulses(4);
            case (i)
                0: otp_hot <= 1'b1;
                1: vdd_above_ovp <= 1'b1;
                2: sd_below_norm <= 1'b1;
                3: sd_below_start <= 1'b1;
                4: aux_above_ovp <= 1'b1;
                5: begin
                    aux_below_uvp <= 1'b1;
                    vdd_above_on <= 1'b0;
                end
                default: cs_below_short <= 1'b1;
            endcase
            // One-cycle pulses give aux samples; the short case keeps the request up
            repeat (20) begin
                pwm_req <= 1'b1;
                @(posedge pclk);
                pwm_req <= (i == 6);
                repeat (10) @(posedge pclk);
            end
            apb(1'b0, OFS_STATUS, 32'h0);
            chk("state", 32'(q[4:0]), 32'(exp_st[i]));
            chk("gate", gate_on, 1'b0);
            chk("tonlim", ton_limit, i == 6);
            apb(1'b0, OFS_FAULT, 32'h0);
            chk("fault", q, 32'h1 << cause[i]);
        end
        print_verdict;
    end
endmodule
